// ---- hdl/dsau_top.sv ----
/*
 * Data space access unit: decodes byte effective addresses onto the word
 * RAM and the special register space, steers bytes, flags misaligned word
 * accesses, updates pointers, widens register bytes and serves table reads.
 * Assumes the core holds no request while an answer is pending; special
 * registers are answered by an external read port, program memory by a
 * program read port that answers in the same cycle its address is issued.
 */
// Function
// - Byte addressed 16-bit words, low byte even
// - Post-increment adds one byte, two word
// - Byte read picks byte onto low lane
// - Byte write drives only selected lane
// - Odd word access raises address trap
// - Read misalignment finishes instruction first
// - Write misalignment suppresses the write
// - Byte load keeps register high byte
// - Signed widen extends eight to sixteen
// - Unsigned widen clears register high byte
// - Special registers occupy 0x0000 to 0x0FFF
// - Unused special addresses read zero
// - Near field of 13 bits
// - Direct 16-bit field or pointer reaches all
// - Program counter steps two per word
// - Low table word returns bits 15:0
// - Low table byte select picks byte
// - High table word zero-fills high byte
// - High table phantom byte reads zero
// - Table page bit 7 selects config
// - Low table low word, high upper byte
// - Unimplemented addresses return zero
module dsau_top
   import dsau_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Data access request and answer
   input  wire dsau_req_t   req,
   output      dsau_rsp_t   rsp,
   // Special register port
   output      logic        sfr_re,
   output      logic        sfr_we,
   output      logic [15:0] sfr_addr,
   output      logic [1:0]  sfr_lane,
   output      logic [15:0] sfr_wdata,
   input  wire logic        sfr_hit,
   input  wire logic [15:0] sfr_rdata,
   // Register byte load and widening
   input  wire logic [15:0] wreg_old,
   input  wire logic [7:0]  wreg_byte,
   input  wire logic        wreg_load,
   input  wire dsau_widen_t wreg_op,
   output      logic [15:0] wreg_new,
   // Table page and table reads
   input  wire logic        page_we,
   input  wire logic [7:0]  page_wdata,
   output      logic [7:0]  program_table_page,
   input  wire dsau_treq_t  treq,
   output      logic        prog_re,
   output      logic        prog_cfg,
   output      logic [22:0] prog_addr,
   input  wire logic [23:0] prog_rdata,
   output      logic        tbl_valid,
   output      logic [15:0] tbl_data,
   // Program counter
   input  wire logic        pc_step,
   output      logic [22:0] program_counter
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_READ} dsau_st_t;

   typedef struct packed {
      dsau_st_t    st;         // Read pipeline state
      logic        rd_ram;     // Pending read from RAM
      logic        rd_sel;     // Byte select of pending read
      logic        rd_byte;    // Pending read is byte
      logic        rd_trap;    // Pending read misaligned
      dsau_rsp_t   rsp;        // Answer
      logic        sfr_re;
      logic        sfr_we;
      logic [15:0] sfr_addr;
      logic [1:0]  sfr_lane;
      logic [15:0] sfr_wdata;
      logic [15:0] wreg_new;
      logic [7:0]  page;       // Table page
      logic        prog_re;
      logic        prog_cfg;
      logic [22:0] prog_addr;
      dsau_tbl_t   t_kind;     // Pending table read
      logic        t_byte;
      logic        t_sel;
      logic        tbl_valid;
      logic [15:0] tbl_data;
      logic [22:0] pc;
   } dsau_state_t;

   dsau_state_t s_q;           // Registered state
   dsau_state_t s_d;           // Next state

   // Decode and helper nets
   logic [15:0]            ea;         // effective_address
   logic                   misalign;   // Odd word access
   logic                   in_sfr;     // Special register range
   logic                   in_ram;     // Implemented RAM
   logic [DSAU_RAM_AW-1:0] ram_addr;   // RAM word index
   logic [1:0]             ram_we;     // RAM lanes
   logic [15:0]            ram_wdata;  // Lane-steered write data
   logic [15:0]            ram_rdata;  // Registered RAM word
   logic [15:0]            tbl_word;   // Mapped table word
   logic [16:0]            ram_off;    // Byte offset into RAM

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   always_comb begin
      case (req.amode)
         DSAU_AM_NEAR13: ea = {3'b000, req.field[DSAU_NEAR_BITS-1:0]};
         DSAU_AM_DIRECT16: ea = req.field;
         default: ea = req.pointer;
      endcase
   end

   assign misalign = req.valid && !req.byte_op && ea[0];
   assign in_sfr   = (ea <= DSAU_SFR_LAST);
   assign ram_off  = {1'b0, ea} - {1'b0, DSAU_RAM_FIRST};
   assign in_ram   = !in_sfr && (ea <= DSAU_IMPL_LAST) && (ram_off[16:1] < {1'b0, DSAU_RAM_WORDS[14:0]});
   assign ram_addr = ram_off[DSAU_RAM_AW:1];
   assign ram_wdata = req.byte_op ? {req.wdata[7:0], req.wdata[7:0]} : req.wdata;

   always_comb begin
      ram_we = 2'b00;
      // Requests in the read answer cycle are refused, so no write then
      if (s_q.st == ST_IDLE && req.valid && req.write && in_ram && !misalign) begin
         ram_we = req.byte_op ? (ea[0] ? 2'b10 : 2'b01) : 2'b11;
      end
   end

   // ----------------------------------------------------------------
   // Leaf modules
   // ----------------------------------------------------------------
   dsau_ram u_ram (
      .clk     (clk),
      .addr    (ram_addr),
      .we_lane (ram_we),
      .wdata   (ram_wdata),
      .rdata   (ram_rdata)
   );

   dsau_tbl u_tbl (
      .kind    (s_q.t_kind),
      .byte_op (s_q.t_byte),
      .byte_sel(s_q.t_sel),
      .pword   (prog_rdata),
      .dword   (tbl_word)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [15:0] word;
      word = 16'h0000;
      s_d  = s_q;
      s_d.rsp.valid  = 1'b0;
      s_d.rsp.ptr_we = 1'b0;
      s_d.rsp.trap   = 1'b0;
      s_d.sfr_re     = 1'b0;
      s_d.sfr_we     = 1'b0;
      s_d.prog_re    = 1'b0;
      s_d.tbl_valid  = 1'b0;
      s_d.t_kind     = DSAU_TB_NONE;
      case (s_q.st)
         ST_IDLE: begin
            if (req.valid) begin
               s_d.rsp.ptr_next = req.pointer + dsau_step(req.byte_op);
               s_d.rsp.ptr_we   = (req.amode == DSAU_AM_IND_POST);
               if (req.write) begin
                  s_d.rsp.valid   = 1'b1;
                  s_d.rsp.trap    = misalign;
                  s_d.rsp.trap_wr = 1'b1;
                  s_d.sfr_we      = in_sfr && !misalign;
                  s_d.sfr_lane    = req.byte_op ? (ea[0] ? 2'b10 : 2'b01) : 2'b11;
                  s_d.sfr_wdata   = ram_wdata;
               end else begin
                  s_d.st      = ST_READ;
                  s_d.sfr_re  = in_sfr;
                  s_d.rd_ram  = in_ram;
                  s_d.rd_sel  = ea[0];
                  s_d.rd_byte = req.byte_op;
                  s_d.rd_trap = misalign;
               end
               s_d.sfr_addr = {ea[15:1], 1'b0};
            end
         end
         ST_READ: begin
            if (s_q.rd_ram) begin
               word = ram_rdata;
            end else if (s_q.sfr_re && sfr_hit) begin
               word = sfr_rdata;
            end
            s_d.rsp.rdata   = s_q.rd_byte ? {8'h00, dsau_pick(word, s_q.rd_sel)} : word;
            s_d.rsp.valid   = 1'b1;
            s_d.rsp.trap    = s_q.rd_trap;
            s_d.rsp.trap_wr = 1'b0;
            s_d.st          = ST_IDLE;
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase

      case (wreg_op)
         DSAU_WX_SIGNED:   s_d.wreg_new = {{8{wreg_old[7]}}, wreg_old[7:0]};
         DSAU_WX_UNSIGNED: s_d.wreg_new = {8'h00, wreg_old[7:0]};
         default:          s_d.wreg_new = wreg_load ? {wreg_old[15:8], wreg_byte} : wreg_old;
      endcase

      // Table page write
      if (page_we) begin
         s_d.page = page_wdata;
      end
      if (treq.valid && (treq.kind != DSAU_TB_NONE)) begin
         s_d.prog_re   = 1'b1;
         s_d.prog_cfg  = s_q.page[DSAU_PAGE_CFG];
         s_d.prog_addr = {s_q.page, treq.offset[15:1]};
         s_d.t_kind    = treq.kind;
         s_d.t_byte    = treq.byte_op;
         s_d.t_sel     = treq.offset[0];
      end
      if (s_q.t_kind != DSAU_TB_NONE) begin
         s_d.tbl_valid = 1'b1;
         s_d.tbl_data  = tbl_word;
      end

      if (pc_step) begin
         s_d.pc = s_q.pc + 23'h000002;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q      <= '0;
         s_q.st   <= ST_IDLE;
         s_q.page <= DSAU_PAGE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops
   assign rsp                = s_q.rsp;
   assign sfr_re             = s_q.sfr_re;
   assign sfr_we             = s_q.sfr_we;
   assign sfr_addr           = s_q.sfr_addr;
   assign sfr_lane           = s_q.sfr_lane;
   assign sfr_wdata          = s_q.sfr_wdata;
   assign wreg_new           = s_q.wreg_new;
   assign program_table_page = s_q.page;
   assign prog_re            = s_q.prog_re;
   assign prog_cfg           = s_q.prog_cfg;
   assign prog_addr          = s_q.prog_addr;
   assign tbl_valid          = s_q.tbl_valid;
   assign tbl_data           = s_q.tbl_data;
   assign program_counter    = s_q.pc;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_trap_on_odd: assert property (@(posedge clk) disable iff (rst)
      (s_q.st == ST_IDLE && req.valid && req.write && !req.byte_op && ea[0]) |=> (rsp.valid && rsp.trap))
      else $error("odd word write did not trap");
   a_no_trap_write: assert property (@(posedge clk) disable iff (rst)
      (req.valid && !req.byte_op && ea[0]) |-> (ram_we == 2'b00))
      else $error("memory written under trap");
   a_byte_lane_one: assert property (@(posedge clk) disable iff (rst)
      (req.byte_op && ram_we != 2'b00) |-> (ram_we == (ea[0] ? 2'b10 : 2'b01)))
      else $error("byte write used wrong lane");
   a_read_trap_late: assert property (@(posedge clk) disable iff (rst)
      (s_q.st == ST_IDLE && req.valid && !req.write && misalign) |-> ##2 (rsp.valid && rsp.trap && !rsp.trap_wr))
      else $error("read trap not after completion");
   a_post_step: assert property (@(posedge clk) disable iff (rst)
      (s_q.st == ST_IDLE && req.valid && req.amode == DSAU_AM_IND_POST)
      |=> (rsp.ptr_we && rsp.ptr_next == $past(req.pointer) + (($past(req.byte_op)) ? 16'h0001 : 16'h0002)))
      else $error("pointer step wrong");
   a_pc_by_two: assert property (@(posedge clk) disable iff (rst)
      pc_step |=> (program_counter == $past(program_counter) + 23'h000002))
      else $error("program counter step wrong");
   a_zero_outside: assert property (@(posedge clk) disable iff (rst)
      (s_q.st == ST_IDLE && req.valid && !req.write && ea > DSAU_IMPL_LAST) |-> ##2 (rsp.rdata == 16'h0000))
      else $error("unimplemented read not zero");
   a_phantom_zero: assert property (@(posedge clk) disable iff (rst)
      (treq.valid && treq.kind == DSAU_TB_HIGH && treq.byte_op && treq.offset[0]) |-> ##2 (tbl_valid && tbl_data == 16'h0000))
      else $error("phantom byte not zero");
   a_page_cfg: assert property (@(posedge clk) disable iff (rst)
      (treq.valid && treq.kind != DSAU_TB_NONE) |=> (prog_re && prog_cfg == $past(program_table_page[7])))
      else $error("table space select wrong");

endmodule : dsau_top

// ---- hdl/dsau_pkg.sv ----
/*
 * Package for the data space access unit: address map limits, access kinds,
 * table read modes and the request/answer structs shared by the design files.
 * Assumes a single core clock domain with a synchronous active-high reset.
 */
package dsau_pkg;

   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   localparam logic [15:0] DSAU_SFR_LAST   = 16'h0FFF;  // Last special register byte
   localparam logic [15:0] DSAU_NEAR_LAST  = 16'h1FFF;  // Last near space byte
   localparam logic [15:0] DSAU_IMPL_LAST  = 16'hCFFF;  // Last implemented byte (52 KB)
   localparam logic [15:0] DSAU_RAM_FIRST  = 16'h1000;  // First RAM byte
   localparam int          DSAU_RAM_AW     = 11;        // RAM word address width
   localparam logic [15:0] DSAU_RAM_WORDS  = 16'h0800;  // Implemented RAM words (2K)
   localparam int          DSAU_NEAR_BITS  = 13;        // Near absolute field width
   localparam logic [7:0]  DSAU_PAGE_RST   = 8'h00;     // Table page reset value
   localparam int          DSAU_PAGE_CFG   = 7;         // Page bit picking config space
   localparam logic [15:0] DSAU_SFR_RST    = 16'h0000;  // Special register reset value
   localparam logic [15:0] DSAU_STEP_BYTE  = 16'h0001;  // Pointer step, byte
   localparam logic [15:0] DSAU_STEP_WORD  = 16'h0002;  // Pointer step, word

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   // Address source of a data access
   typedef enum logic [1:0] {
      DSAU_AM_DIRECT16,  // 16-bit direct field
      DSAU_AM_NEAR13,    // 13-bit absolute field
      DSAU_AM_IND,       // Pointer register
      DSAU_AM_IND_POST   // Pointer register, post-increment
   } dsau_amode_t;

   // Kind of table read
   typedef enum logic [1:0] {
      DSAU_TB_NONE,
      DSAU_TB_LOW,       // table_read_low_word
      DSAU_TB_HIGH       // table_read_high_byte
   } dsau_tbl_t;

   // Register byte operation
   typedef enum logic [1:0] {
      DSAU_WX_NONE,
      DSAU_WX_SIGNED,    // signed_widen_op
      DSAU_WX_UNSIGNED   // unsigned_widen_op
   } dsau_widen_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        valid;     // Access request
      logic        write;     // 1 write, 0 read
      logic        byte_op;   // 1 byte, 0 word
      dsau_amode_t amode;     // Address source
      logic [15:0] field;     // Direct or near field
      logic [15:0] pointer;   // source_pointer_reg value
      logic [15:0] wdata;     // Write data, byte in low lane
   } dsau_req_t;

   typedef struct packed {
      logic        valid;     // Answer valid
      logic [15:0] rdata;     // Read data, byte on low lane
      logic [15:0] ptr_next;  // Pointer after update
      logic        ptr_we;    // Pointer update strobe
      logic        trap;      // Address error trap
      logic        trap_wr;   // Trap came from a write
   } dsau_rsp_t;

   typedef struct packed {
      logic        valid;     // Table read request
      dsau_tbl_t   kind;      // Low word or high byte
      logic        byte_op;   // Byte mode
      logic [15:0] offset;    // Offset, bit 0 is byte select
   } dsau_treq_t;

   // ----------------------------------------------------------------
   // Shared functions
   // ----------------------------------------------------------------
   // Pointer step for byte or word access
   function automatic logic [15:0] dsau_step(input logic byte_op);
      dsau_step = byte_op ? DSAU_STEP_BYTE : DSAU_STEP_WORD;
   endfunction : dsau_step

   // Pick a byte from a word by address bit 0
   function automatic logic [7:0] dsau_pick(input logic [15:0] w, input logic sel);
      dsau_pick = sel ? w[15:8] : w[7:0];
   endfunction : dsau_pick

endpackage : dsau_pkg

// ---- hdl/dsau_ram.sv ----
/*
 * Word-wide data RAM with two byte write lanes and a shared word decode.
 * Read data comes out of a register one cycle after the address.
 */
module dsau_ram
   import dsau_pkg::*;
(
   // Clock
   input  wire logic                   clk,
   // Port
   input  wire logic [DSAU_RAM_AW-1:0] addr,
   input  wire logic [1:0]             we_lane,
   input  wire logic [15:0]            wdata,
   output      logic [15:0]            rdata
);

   // Storage array
   logic [15:0] mem [0:(1<<DSAU_RAM_AW)-1];

   // ----------------------------------------------------------------
   // Lane writes, registered read
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (we_lane[0]) begin
         mem[addr][7:0] <= wdata[7:0];
      end
      if (we_lane[1]) begin
         mem[addr][15:8] <= wdata[15:8];
      end
      rdata <= mem[addr];
   end

endmodule : dsau_ram

// ---- hdl/dsau_tbl.sv ----
/*
 * Table read mapper: turns a 24-bit program word into a data word for the
 * low-word and high-byte table reads; the program address is formed in dsau_top.
 * Assumes program data is valid in the same cycle the address is issued.
 */
module dsau_tbl
   import dsau_pkg::*;
(
   // Control
   input  wire dsau_tbl_t   kind,
   input  wire logic        byte_op,
   input  wire logic        byte_sel,
   // Program word
   input  wire logic [23:0] pword,
   // Result
   output      logic [15:0] dword
);

   // ----------------------------------------------------------------
   // Lane mapping
   // ----------------------------------------------------------------
   always_comb begin
      dword = 16'h0000;
      case (kind)
         DSAU_TB_LOW: begin
            dword = byte_op ? {8'h00, dsau_pick(pword[15:0], byte_sel)} : pword[15:0];
         end
         DSAU_TB_HIGH: begin
            dword = (byte_op && byte_sel) ? 16'h0000 : {8'h00, pword[23:16]};
         end
         default: begin
            dword = 16'h0000;
         end
      endcase
   end

endmodule : dsau_tbl

// ---- bench/dsau_far_model.sv ----
/*
 * Far side model: special register responder and program memory.
 * Assumes the unit's port outputs are registered on clk.
 */
module dsau_far_model (
   // Clock
   input  wire logic        clk,
   // Special register port
   input  wire logic [15:0] sfr_addr,
   output      logic        sfr_hit,
   output      logic [15:0] sfr_rdata,
   // Program port
   input  wire logic        prog_re,
   input  wire logic        prog_cfg,
   input  wire logic [22:0] prog_addr,
   output      logic [23:0] prog_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] junk_q = 16'h0000;  // Changes every cycle

   // Only one special register exists; absent ones drive junk
   assign sfr_hit   = (sfr_addr == 16'h0E60);
   assign sfr_rdata = sfr_hit ? 16'hA5C3 : junk_q;

   // Program word valid while the read strobe stands, junk otherwise
   assign prog_rdata = prog_re ? ({prog_cfg, prog_addr} ^ 24'h3C5A96) : {junk_q, 8'h5F};

   // Junk pattern moves every cycle
   always @(posedge clk) begin
      junk_q <= junk_q + 16'h3B1D;
   end
endmodule : dsau_far_model

// ---- bench/tb_top.sv ----
/*
 * Self-checking bench for the data space access unit.
 * Assumes the far side model answers the special and program ports.
 */
module tb_top
   import dsau_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst = 1'b1, sfr_re, sfr_we, sfr_hit, wreg_load, page_we, prog_re, prog_cfg;
   logic tbl_valid, pc_step, saw_re, saw_we;
   logic [15:0] sfr_addr, sfr_wdata, sfr_rdata, wreg_old, wreg_new, tbl_data;
   logic [1:0]  sfr_lane;
   logic [7:0]  wreg_byte, page_wdata, program_table_page;
   logic [22:0] prog_addr, program_counter;
   logic [23:0] prog_rdata;
   dsau_req_t   req;
   dsau_rsp_t   rsp, r;
   dsau_treq_t  treq;
   dsau_widen_t wreg_op;
   int          fails = 0, n_checks = 0;

   always #20 clk = ~clk;
   // Remember special register strobes
   always @(posedge clk) begin
      if (sfr_re === 1'b1) saw_re <= 1'b1;
      if (sfr_we === 1'b1) saw_we <= 1'b1;
   end

   dsau_top i_dut (.clk(clk), .rst(rst), .req(req), .rsp(rsp), .sfr_re(sfr_re), .sfr_we(sfr_we),
      .sfr_addr(sfr_addr), .sfr_lane(sfr_lane), .sfr_wdata(sfr_wdata), .sfr_hit(sfr_hit),
      .sfr_rdata(sfr_rdata), .wreg_old(wreg_old), .wreg_byte(wreg_byte), .wreg_load(wreg_load),
      .wreg_op(wreg_op), .wreg_new(wreg_new), .page_we(page_we), .page_wdata(page_wdata),
      .program_table_page(program_table_page), .treq(treq), .prog_re(prog_re), .prog_cfg(prog_cfg),
      .prog_addr(prog_addr), .prog_rdata(prog_rdata), .tbl_valid(tbl_valid), .tbl_data(tbl_data),
      .pc_step(pc_step), .program_counter(program_counter));
   dsau_far_model i_far (.clk(clk), .sfr_addr(sfr_addr), .sfr_hit(sfr_hit), .sfr_rdata(sfr_rdata),
      .prog_re(prog_re), .prog_cfg(prog_cfg), .prog_addr(prog_addr), .prog_rdata(prog_rdata));

   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test

   // Compare seen against expected
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One data access, answer left in r
   task automatic acc(input logic wr, input logic bt, input dsau_amode_t am, input logic [15:0] fld,
                      input logic [15:0] ptr, input logic [15:0] wd);
      int i;
      @(posedge clk) req <= '{1'b1, wr, bt, am, fld, ptr, wd};
      @(posedge clk) req.valid <= 1'b0;
      for (i = 0; i < 5; i++) begin
         #1;
         if (rsp.valid === 1'b1) break;
         @(posedge clk);
      end
      if (i == 5) begin
         fails++;
         stop_test();
      end
      r = rsp;
      @(posedge clk);
   endtask : acc

   // RAM lanes and byte steering
   task automatic t_ram();
      acc(1'b1, 1'b0, DSAU_AM_DIRECT16, 16'h1000, 16'h0000, 16'h1234);
      chk(r.trap, 1'b0);
      acc(1'b1, 1'b1, DSAU_AM_DIRECT16, 16'h1001, 16'h0000, 16'h00AB);
      acc(1'b0, 1'b0, DSAU_AM_DIRECT16, 16'h1000, 16'h0000, 16'h0000);
      chk(r.rdata, 16'hAB34);
      acc(1'b0, 1'b1, DSAU_AM_DIRECT16, 16'h1001, 16'h0000, 16'h0000);
      chk(r.rdata, 16'h00AB);
      acc(1'b0, 1'b1, DSAU_AM_DIRECT16, 16'h1000, 16'h0000, 16'h0000);
      chk(r.rdata, 16'h0034);
      $display("done ram");
   endtask : t_ram

   // Misaligned word accesses
   task automatic t_trap();
      acc(1'b1, 1'b0, DSAU_AM_DIRECT16, 16'h1001, 16'h0000, 16'hFFFF);
      chk({r.trap, r.trap_wr}, 2'b11);
      acc(1'b0, 1'b0, DSAU_AM_DIRECT16, 16'h1001, 16'h0000, 16'h0000);
      chk({r.trap, r.trap_wr, r.rdata}, {2'b10, 16'hAB34});
      $display("done trap");
   endtask : t_trap

   // Pointer modes and address spaces
   task automatic t_space();
      int b;
      for (b = 0; b < 2; b++) begin
         acc(1'b1, b[0], DSAU_AM_IND_POST, 16'h0000, 16'h1010, 16'h0000);
         chk({r.ptr_we, r.ptr_next}, {1'b1, 16'h1010 + (b ? 16'h0001 : 16'h0002)});
      end
      saw_re = 1'b0;
      acc(1'b0, 1'b0, DSAU_AM_IND, 16'h0000, 16'h1000, 16'h0000);
      chk({saw_re, r.ptr_we, r.rdata}, {2'b00, 16'hAB34});
      acc(1'b0, 1'b0, DSAU_AM_DIRECT16, 16'h0E60, 16'h0000, 16'h0000);
      chk({saw_re, r.rdata}, {1'b1, 16'hA5C3});
      acc(1'b0, 1'b0, DSAU_AM_DIRECT16, 16'h0E70, 16'h0000, 16'h0000);
      chk(r.rdata, 16'h0000);
      acc(1'b1, 1'b1, DSAU_AM_DIRECT16, 16'h0E61, 16'h0000, 16'h005A);
      #1 chk({saw_we, sfr_lane, sfr_addr, sfr_wdata}, {1'b1, 2'b10, 16'h0E60, 16'h5A5A});
      acc(1'b1, 1'b0, DSAU_AM_DIRECT16, 16'h2000, 16'h0000, 16'h5555);
      acc(1'b0, 1'b0, DSAU_AM_DIRECT16, 16'h2000, 16'h0000, 16'h0000);
      chk(r.rdata, 16'h0000);
      acc(1'b0, 1'b0, DSAU_AM_DIRECT16, 16'hE000, 16'h0000, 16'h0000);
      chk(r.rdata, 16'h0000);
      acc(1'b0, 1'b0, DSAU_AM_NEAR13, 16'hF000, 16'h0000, 16'h0000);
      chk(r.rdata, 16'hAB34);
      $display("done space");
   endtask : t_space

   // One register widen or byte load
   task automatic wx(input dsau_widen_t op, input logic ld, input logic [15:0] old, input logic [7:0] bv,
                     input logic [15:0] exp);
      @(posedge clk) begin
         wreg_op   <= op;
         wreg_load <= ld;
         wreg_old  <= old;
         wreg_byte <= bv;
      end
      @(posedge clk);
      @(posedge clk) #1 chk(wreg_new, exp);
   endtask : wx

   // Table reads in every mode for both pages
   task automatic t_table();
      logic [7:0]  pg;
      logic [15:0] off, e;
      logic [23:0] pw;
      int p, m, i;
      for (p = 0; p < 2; p++) begin
         pg = p ? 8'h80 : 8'h00;
         @(posedge clk) begin
            page_we    <= 1'b1;
            page_wdata <= pg;
         end
         @(posedge clk) page_we <= 1'b0;
         for (m = 0; m < 6; m++) begin
            off = 16'h2468 | ((m == 2 || m == 5) ? 16'h0001 : 16'h0000);
            pw  = {pg[7], pg, off[15:1]} ^ 24'h3C5A96;
            case (m)
               0: e = pw[15:0];
               1: e = {8'h00, pw[7:0]};
               2: e = {8'h00, pw[15:8]};
               5: e = 16'h0000;
               default: e = {8'h00, pw[23:16]};
            endcase
            @(posedge clk) treq <= '{1'b1, (m < 3) ? DSAU_TB_LOW : DSAU_TB_HIGH, (m != 0 && m != 3), off};
            @(posedge clk) treq.valid <= 1'b0;
            for (i = 0; i < 5; i++) begin
               #1;
               if (tbl_valid === 1'b1) break;
               @(posedge clk);
            end
            if (i == 5) begin
               fails++;
               stop_test();
            end
            chk(tbl_data, e);
            chk(program_table_page, pg);
         end
      end
      $display("done table");
   endtask : t_table

   // Program counter steps
   task automatic t_pc();
      logic [22:0] p;
      #1 p = program_counter;
      @(posedge clk) pc_step <= 1'b1;
      @(posedge clk);
      @(posedge clk) pc_step <= 1'b0;
      @(posedge clk) #1 chk(program_counter, p + 23'h000004);
      $display("done pc");
   endtask : t_pc

   // Main sequence
   initial begin
      req = '0;
      treq = '0;
      wreg_old = 16'h0000;
      wreg_byte = 8'h00;
      wreg_load = 1'b0;
      wreg_op = DSAU_WX_NONE;
      page_we = 1'b0;
      page_wdata = 8'h00;
      pc_step = 1'b0;
      saw_re = 1'b0;
      saw_we = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_ram();
      t_trap();
      t_space();
      wx(DSAU_WX_NONE, 1'b1, 16'hABCD, 8'h12, 16'hAB12);
      wx(DSAU_WX_SIGNED, 1'b0, 16'h1280, 8'h80, 16'hFF80);
      wx(DSAU_WX_SIGNED, 1'b0, 16'hFF7F, 8'h7F, 16'h007F);
      wx(DSAU_WX_UNSIGNED, 1'b0, 16'hABCD, 8'hCD, 16'h00CD);
      $display("done widen");
      t_table();
      t_pc();
      stop_test();
   end
endmodule : tb_top
